// ### rtl/cps_defs.vh
`ifndef CPS_DEFS_VH
`define CPS_DEFS_VH

// serial frame: 1 r/w bit, 7 address bits, 8 data bits
`define CPS_ADDR_W          7
`define CPS_DATA_W          8
`define CPS_FRAME_BITS      5'h10
`define CPS_CMD_BITS        5'h08
`define CPS_RW_BIT          7

// register indices
`define CPS_REG_IN12_FREQ   7'h10
`define CPS_REG_IN34_FREQ   7'h11
`define CPS_REG_OUT_FREQ_A  7'h22
`define CPS_REG_OUT_FREQ_B  7'h26
`define CPS_REG_SYNC_CTRL   7'h30
`define CPS_REG_STATUS      7'h31

// field positions
`define CPS_FAM_BIT_A       2
`define CPS_FAM_BIT_B0      5
`define CPS_FAM_BIT_B1      6
`define CPS_STAT_SWITCH     0
`define CPS_STAT_FAMILY     1

// reset values: input codes 8 kHz / 19.44 kHz, output codes
`define CPS_RST_IN12        8'h11
`define CPS_RST_IN34        8'h33
`define CPS_RST_OUT_A       8'h41
`define CPS_RST_OUT_B       8'h12
`define CPS_RST_SYNC_CTRL   8'h00

// timing: 20 MHz system clock
`define CPS_CLK_HZ          20000000
`define CPS_FRAME_HZ        8000
`define CPS_FRAME_DIV       (`CPS_CLK_HZ / `CPS_FRAME_HZ)
`define CPS_MF_RATIO        2'h3
`define CPS_CNT_W           12

`endif

// ### rtl/cps_sync2.v
`timescale 1ns/1ps
// two-stage synchroniser for a pin input
module cps_sync2 (
    // clock and reset
    input  wire i_clk_sys,
    input  wire i_rst_n,
    // pin and synchronised level
    input  wire i_d,
    output reg  o_q
);
    reg meta;

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= 1'b0;
            o_q  <= 1'b0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule // cps_sync2

// ### rtl/cps_control_pins.v
// Operation
// - serial port responds only while chip select is held low.
// - edge-select strap high makes falling serial clock edge active.
// - default edge setting captures serial input on rising serial clock.
// - read data returns on dedicated SPI-style serial output.
// - master reset low returns registers, counters, bit count and serial output to defaults.
// - rate-family strap loads frequency bit 2 of reg 34, bits 5,6 of reg 38.
// - strap low selects 2.048 MHz family; high selects 1.544 MHz family.
// - software writes override strap-loaded frequency selection bits.
// - source-switch input forces fast switching between references 1 and 2.
// - 8 kHz frame pulse driven on frame sync output.
// - 2 kHz multi-frame pulse driven on multi-frame sync output.
// - references 1,2 default 8 kHz, references 3,4 19.44 kHz.
// - output frequency defaults 38.88, 38.88, 19.44, 1.544/2.048 MHz.
`timescale 1ns/1ps
`include "cps_defs.vh"
module cps_control_pins (
    // clock and reset
    input  wire       i_clk_sys,
    input  wire       i_rst_n,
    // straps and control pins
    input  wire       i_master_reset_n,
    input  wire       i_rate_family_strap,
    input  wire       i_serial_edge_select,
    input  wire       i_force_fast_switch_in,
    // serial host port
    input  wire       i_serial_clk,
    input  wire       i_chip_select_n,
    input  wire       i_serial_in,
    output reg        o_serial_out,
    output reg        o_serial_out_en_n,
    // configuration seen by the timing core
    output reg  [7:0] o_in12_freq,
    output reg  [7:0] o_in34_freq,
    output reg  [7:0] o_out_freq_a,
    output reg  [7:0] o_out_freq_b,
    output reg        o_fast_switch,
    // sync pulses
    output reg        o_frame_pulse_out,
    output reg        o_multiframe_pulse_out
);
    // ==========================================================
    // input synchronisers
    // ==========================================================
    wire mrst_s;
    wire strap_s;
    wire edge_s;
    wire sw_s;
    wire sclk_s;
    wire csn_s;
    wire sdi_s;

    cps_sync2 u_s_mrst  (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_master_reset_n),      .o_q(mrst_s));
    cps_sync2 u_s_strap (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_rate_family_strap),   .o_q(strap_s));
    cps_sync2 u_s_edge  (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_serial_edge_select),  .o_q(edge_s));
    cps_sync2 u_s_sw    (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_force_fast_switch_in), .o_q(sw_s));
    cps_sync2 u_s_sclk  (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_serial_clk),          .o_q(sclk_s));
    cps_sync2 u_s_csn   (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_chip_select_n),       .o_q(csn_s));
    cps_sync2 u_s_sdi   (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_serial_in),           .o_q(sdi_s));

    // ==========================================================
    // master reset and strap capture
    // ==========================================================
    reg  sclk_d;
    reg  soft_rst;
    reg  strap_load;

    // soft reset while the master reset pin is low, strap loaded on release
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            soft_rst   <= 1'b1;
            strap_load <= 1'b1;
        end else begin
            soft_rst   <= ~mrst_s;
            strap_load <= ~mrst_s | soft_rst;
        end
    end

    // ==========================================================
    // serial clock edge detect
    // ==========================================================
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire cap_edge  = edge_s ? sclk_fall : sclk_rise;
    wire out_edge  = edge_s ? sclk_rise : sclk_fall;
    wire active    = ~csn_s;

    // ==========================================================
    // serial shift engine
    // ==========================================================
    reg  [4:0]  bit_cnt;
    reg  [15:0] shift_in;
    reg  [7:0]  shift_out;
    reg         wr_pend;
    wire [15:0] next_shift_in = {shift_in[`CPS_FRAME_BITS-2:0], sdi_s};
    wire [6:0]  cmd_addr      = shift_in[`CPS_ADDR_W-1:0];
    wire        cmd_read      = shift_in[`CPS_RW_BIT];
    reg  [7:0]  rd_data;

    always @* begin
        case (cmd_addr)
            `CPS_REG_IN12_FREQ:  rd_data = o_in12_freq;
            `CPS_REG_IN34_FREQ:  rd_data = o_in34_freq;
            `CPS_REG_OUT_FREQ_A: rd_data = o_out_freq_a;
            `CPS_REG_OUT_FREQ_B: rd_data = o_out_freq_b;
            `CPS_REG_SYNC_CTRL:  rd_data = `CPS_RST_SYNC_CTRL;
            `CPS_REG_STATUS: begin
                rd_data = 8'h00;
                rd_data[`CPS_STAT_SWITCH] = o_fast_switch;
                rd_data[`CPS_STAT_FAMILY] = strap_s;
            end
            default:             rd_data = 8'h00;
        endcase
    end

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_d            <= 1'b0;
            bit_cnt           <= 5'h00;
            shift_in          <= 16'h0000;
            shift_out         <= 8'h00;
            wr_pend           <= 1'b0;
            o_serial_out      <= 1'b0;
            o_serial_out_en_n <= 1'b1;
        end else begin
            sclk_d  <= sclk_s;
            wr_pend <= 1'b0;
            if (soft_rst || !active) begin
                bit_cnt           <= 5'h00;
                o_serial_out      <= 1'b0;
                o_serial_out_en_n <= 1'b1;
            end else begin
                if (cap_edge && bit_cnt != `CPS_FRAME_BITS) begin
                    shift_in <= next_shift_in;
                    bit_cnt  <= bit_cnt + 5'h01;
                    if (bit_cnt == `CPS_FRAME_BITS - 5'h01)
                        wr_pend <= ~shift_in[`CPS_RW_BIT + `CPS_CMD_BITS - 1];
                end
                if (bit_cnt == `CPS_CMD_BITS && cmd_read && out_edge) begin
                    // read data shifted out msb first on the opposite edge
                    o_serial_out_en_n <= 1'b0;
                    o_serial_out      <= rd_data[`CPS_DATA_W-1];
                    shift_out         <= {rd_data[`CPS_DATA_W-2:0], 1'b0};
                end else if (!o_serial_out_en_n && out_edge) begin
                    o_serial_out <= shift_out[`CPS_DATA_W-1];
                    shift_out    <= {shift_out[`CPS_DATA_W-2:0], 1'b0};
                end
            end
        end
    end

    // ==========================================================
    // configuration registers
    // ==========================================================
    wire [6:0] wr_addr = shift_in[`CPS_DATA_W+`CPS_ADDR_W-1:`CPS_DATA_W];
    wire [7:0] wr_data = shift_in[`CPS_DATA_W-1:0];

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_in12_freq  <= `CPS_RST_IN12;
            o_in34_freq  <= `CPS_RST_IN34;
            o_out_freq_a <= `CPS_RST_OUT_A;
            o_out_freq_b <= `CPS_RST_OUT_B;
        end else if (soft_rst) begin
            o_in12_freq  <= `CPS_RST_IN12;
            o_in34_freq  <= `CPS_RST_IN34;
            o_out_freq_a <= `CPS_RST_OUT_A;
            o_out_freq_b <= `CPS_RST_OUT_B;
        end else if (strap_load) begin
            // strap high = 1.544 MHz family, low = 2.048 MHz family
            o_out_freq_a[`CPS_FAM_BIT_A]  <= strap_s;
            o_out_freq_b[`CPS_FAM_BIT_B0] <= strap_s;
            o_out_freq_b[`CPS_FAM_BIT_B1] <= strap_s;
        end else if (wr_pend) begin
            case (wr_addr)
                `CPS_REG_IN12_FREQ:  o_in12_freq  <= wr_data;
                `CPS_REG_IN34_FREQ:  o_in34_freq  <= wr_data;
                `CPS_REG_OUT_FREQ_A: o_out_freq_a <= wr_data;
                `CPS_REG_OUT_FREQ_B: o_out_freq_b <= wr_data;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // fast switch and sync pulses
    // ==========================================================
    reg [`CPS_CNT_W-1:0] frm_cnt;
    reg [1:0]            mf_cnt;

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fast_switch          <= 1'b0;
            frm_cnt                <= {`CPS_CNT_W{1'b0}};
            mf_cnt                 <= 2'h0;
            o_frame_pulse_out      <= 1'b0;
            o_multiframe_pulse_out <= 1'b0;
        end else if (soft_rst) begin
            o_fast_switch          <= 1'b0;
            frm_cnt                <= {`CPS_CNT_W{1'b0}};
            mf_cnt                 <= 2'h0;
            o_frame_pulse_out      <= 1'b0;
            o_multiframe_pulse_out <= 1'b0;
        end else begin
            o_fast_switch <= sw_s;
            if (frm_cnt == `CPS_FRAME_DIV - 1) begin
                frm_cnt           <= {`CPS_CNT_W{1'b0}};
                o_frame_pulse_out <= 1'b1;
                mf_cnt            <= mf_cnt + 2'h1;
                o_multiframe_pulse_out <= (mf_cnt == `CPS_MF_RATIO);
            end else begin
                frm_cnt                <= frm_cnt + {{(`CPS_CNT_W-1){1'b0}}, 1'b1};
                o_frame_pulse_out      <= 1'b0;
                o_multiframe_pulse_out <= 1'b0;
            end
        end
    end
endmodule // cps_control_pins

// ### verif/cps_checker.sv
`timescale 1ns/1ps
`include "cps_defs.vh"
module cps_checker (
    // clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    // pins
    input wire logic       i_master_reset_n,
    input wire logic       i_rate_family_strap,
    input wire logic       i_force_fast_switch_in,
    input wire logic       i_chip_select_n,
    // outputs
    input wire logic       o_serial_out,
    input wire logic       o_serial_out_en_n,
    input wire logic [7:0] o_in12_freq,
    input wire logic [7:0] o_in34_freq,
    input wire logic [7:0] o_out_freq_a,
    input wire logic [7:0] o_out_freq_b,
    input wire logic       o_fast_switch,
    input wire logic       o_frame_pulse_out,
    input wire logic       o_multiframe_pulse_out
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // ==========
    // frame gap counter, restarted by each frame pulse; seen cleared by master reset
    logic [11:0] gap;
    logic        seen;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap  <= 12'h000;
            seen <= 1'b0;
        end else begin
            gap  <= o_frame_pulse_out ? 12'h000 : gap + 12'h001;
            seen <= i_master_reset_n & (seen | o_frame_pulse_out);
        end
    end
    sequence s_rst_rel;
        $rose(i_rst_n);
    endsequence
    sequence s_mrst_rel;
        $rose(i_master_reset_n);
    endsequence
    // ==========
    // checks
    chk_reset_vals: assert property (s_rst_rel |-> o_in12_freq == `CPS_RST_IN12 && o_in34_freq == `CPS_RST_IN34
        && o_serial_out_en_n && !o_frame_pulse_out) else $error("defaults wrong after reset");
    chk_mreset_vals: assert property (s_mrst_rel |-> o_in34_freq == `CPS_RST_IN34
        && (o_out_freq_b & 8'h9f) == `CPS_RST_OUT_B) else $error("defaults wrong after master reset");
    chk_strap_load: assert property ((s_rst_rel or s_mrst_rel) ##8 1 |->
        o_out_freq_a[2] == i_rate_family_strap && o_out_freq_b[6:5] == {2{i_rate_family_strap}})
        else $error("strap not loaded");
    chk_fast_switch: assert property ($stable(i_force_fast_switch_in)[*4] |->
        o_fast_switch == i_force_fast_switch_in) else $error("fast switch not following pin");
    chk_idle_release: assert property (i_chip_select_n[*5] |-> o_serial_out_en_n && !o_serial_out)
        else $error("serial out not released");
    chk_en_holds: assert property ((!i_chip_select_n)[*4] ##0 !o_serial_out_en_n |=> !o_serial_out_en_n)
        else $error("serial out dropped mid frame");
    chk_frame_gap: assert property (o_frame_pulse_out && seen |-> gap == 12'h9c3)
        else $error("frame pulse spacing wrong");
    chk_mf_on_frame: assert property (o_multiframe_pulse_out |-> o_frame_pulse_out)
        else $error("multiframe pulse off frame");
endmodule // cps_checker
bind cps_control_pins cps_checker cps_checker_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_master_reset_n(i_master_reset_n), .i_rate_family_strap(i_rate_family_strap),
    .i_force_fast_switch_in(i_force_fast_switch_in), .i_chip_select_n(i_chip_select_n),
    .o_serial_out(o_serial_out), .o_serial_out_en_n(o_serial_out_en_n), .o_in12_freq(o_in12_freq),
    .o_in34_freq(o_in34_freq), .o_out_freq_a(o_out_freq_a), .o_out_freq_b(o_out_freq_b),
    .o_fast_switch(o_fast_switch), .o_frame_pulse_out(o_frame_pulse_out),
    .o_multiframe_pulse_out(o_multiframe_pulse_out));

// ### verif/cps_host_model.sv
`timescale 1ns/1ps
module cps_host_model (
    // clock
    input  wire logic i_clk_sys,
    // serial port pins
    input  wire logic i_edge_sel,
    input  wire logic i_serial_out,
    output logic      o_serial_clk,
    output logic      o_chip_select_n,
    output logic      o_serial_in
);
    initial begin
        o_serial_clk    = 1'b0;
        o_chip_select_n = 1'b1;
        o_serial_in     = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge i_clk_sys);
    endtask
    // frame msb first; a short count aborts it
    task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rdat);
        rdat = 8'h00;
        o_serial_clk <= i_edge_sel;
        half();
        o_chip_select_n <= 1'b0;
        half();
        for (int i = 0; i < nbits; i++) begin
            o_serial_in <= frame[15 - i];
            half();
            o_serial_clk <= !i_edge_sel;
            half();
            // read bit stood since the previous opposite edge
            if (i >= 8)
                rdat[15 - i] = i_serial_out;
            o_serial_clk <= i_edge_sel;
        end
        half();
        o_chip_select_n <= 1'b1;
        o_serial_in     <= !o_serial_in;
    endtask
endmodule // cps_host_model

// ### verif/test_control_pins_and_serial_port.sv
`timescale 1ns/1ps
`include "cps_defs.vh"
module test_control_pins_and_serial_port;
    logic        clk = 1'b0, rst_n = 1'b0, mrst_n = 1'b1, strap = 1'b0, esel = 1'b0, fsw = 1'b0;
    wire         sclk, cs_n, serial_in, serial_out, sdo_en_n, fsw_q, fp, mfp;
    wire [7:0]   in12, in34, oa, ob;
    int          failures = 0, cmp_count = 0;
    logic [31:0] seed = 32'h19989247;
    logic [7:0]  rd, wd;
    logic [6:0]  regs [4] = '{`CPS_REG_IN12_FREQ, `CPS_REG_IN34_FREQ, `CPS_REG_OUT_FREQ_A, `CPS_REG_OUT_FREQ_B};
    always #25 clk = !clk;
    cps_control_pins cps_control_pins_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_master_reset_n(mrst_n),
        .i_rate_family_strap(strap), .i_serial_edge_select(esel), .i_force_fast_switch_in(fsw),
        .i_serial_clk(sclk), .i_chip_select_n(cs_n), .i_serial_in(serial_in), .o_serial_out(serial_out),
        .o_serial_out_en_n(sdo_en_n), .o_in12_freq(in12), .o_in34_freq(in34), .o_out_freq_a(oa),
        .o_out_freq_b(ob), .o_fast_switch(fsw_q), .o_frame_pulse_out(fp), .o_multiframe_pulse_out(mfp));
    cps_host_model cps_host_model_inst (.i_clk_sys(clk), .i_edge_sel(esel), .i_serial_out(serial_out),
        .o_serial_clk(sclk), .o_chip_select_n(cs_n), .o_serial_in(serial_in));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] exp_a(input logic s);
        exp_a = `CPS_RST_OUT_A;
        exp_a[`CPS_FAM_BIT_A] = s;
    endfunction
    function automatic logic [7:0] exp_b(input logic s);
        exp_b = `CPS_RST_OUT_B;
        exp_b[`CPS_FAM_BIT_B0] = s;
        exp_b[`CPS_FAM_BIT_B1] = s;
    endfunction
    function automatic logic [7:0] port_of(input logic [6:0] a);
        return a == `CPS_REG_IN12_FREQ ? in12 : a == `CPS_REG_IN34_FREQ ? in34 : a == `CPS_REG_OUT_FREQ_A ? oa : ob;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d, input int n);
        cps_host_model_inst.xfer({rw, a, d}, n, rd);
    endtask
    task automatic results();
        $display("counts: %0d compared, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        wait_clk(60000);
        failures++;
        results();
    end
    initial begin
        int nf;
        int nm;
        strap <= seed[0];
        wait_clk(20);
        rst_n <= 1'b1;
        wait_clk(10);
        chk(in12, `CPS_RST_IN12);
        chk(in34, `CPS_RST_IN34);
        chk(oa, exp_a(strap));
        chk(ob, exp_b(strap));
        $display("test reset defaults done");
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            wd = seed[7:0];
            esel <= k[2];
            wait_clk(2);
            xfer(1'b0, regs[k % 4], wd, 16);
            wait_clk(4);
            chk(port_of(regs[k % 4]), wd);
            xfer(1'b1, regs[k % 4], 8'h00, 16);
            chk(rd, wd);
        end
        xfer(1'b1, 7'h7f, 8'h00, 16);
        chk(rd, 8'h00);
        xfer(1'b0, `CPS_REG_SYNC_CTRL, wd, 16);
        xfer(1'b1, `CPS_REG_SYNC_CTRL, 8'h00, 16);
        chk(rd, `CPS_RST_SYNC_CTRL);
        $display("test write and read done");
        xfer(1'b0, `CPS_REG_IN12_FREQ, 8'h5a, 16);
        xfer(1'b0, `CPS_REG_IN12_FREQ, 8'ha5, 12);
        wait_clk(4);
        chk(in12, 8'h5a);
        xfer(1'b1, `CPS_REG_IN12_FREQ, 8'h00, 16);
        chk(rd, 8'h5a);
        $display("test abort done");
        fsw <= 1'b1;
        wait_clk(6);
        chk({7'h00, fsw_q}, 8'h01);
        xfer(1'b1, `CPS_REG_STATUS, 8'h00, 16);
        chk(rd, {6'h00, strap, 1'b1});
        fsw <= 1'b0;
        strap <= seed[9];
        mrst_n <= 1'b0;
        wait_clk(10);
        mrst_n <= 1'b1;
        wait_clk(10);
        chk(in12, `CPS_RST_IN12);
        chk(oa, exp_a(strap));
        chk(ob, exp_b(strap));
        xfer(1'b1, `CPS_REG_STATUS, 8'h00, 16);
        chk(rd, {6'h00, strap, 1'b0});
        $display("test master reset done");
        nf = 0;
        nm = 0;
        repeat (10000) begin
            @(posedge clk);
            nf += fp;
            nm += mfp;
        end
        chk(nf[7:0], 8'h04);
        chk(nm[7:0], 8'h01);
        $display("test sync pulses done");
        results();
    end
endmodule // test_control_pins_and_serial_port
